// >>> rtl/aiocp_pkg.sv
// Constants and types shared by the analog I/O coding and pacing block
package aiocp_pkg;
    // Clock and time base
    localparam int unsigned CLK_PS        = 4000;
    localparam int unsigned TICK_NS       = 200;
    localparam int unsigned TICK_CYC      = (TICK_NS * 1000) / CLK_PS;
    localparam int unsigned MIN_PACE_TICKS = 30;
    // Least conversion spacing, single channel and scanning
    localparam int unsigned SINGLE_MIN_NS = 3000;
    localparam int unsigned SCAN_MIN_NS   = 3205;
    localparam int unsigned SINGLE_MIN_CYC = (SINGLE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned SCAN_MIN_CYC   = (SCAN_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // Output rate ceiling of 500 kHz, as ticks of the master tick
    localparam int unsigned AO_MIN_NS     = 2000;
    localparam logic [15:0] AO_MIN_TICKS  = 16'((AO_MIN_NS + TICK_NS - 1) / TICK_NS);
    // Widths and depths
    localparam int unsigned AD_W          = 16;
    localparam int unsigned AI_FIFO_DEPTH = 4;
    localparam int unsigned AO_DEPTH      = 2048;
    localparam int unsigned AO_AW         = 11;
    localparam int unsigned GUARD_W       = 10;
    // Coding
    localparam logic [11:0] CODE_MSB12    = 12'h800;
    localparam logic [15:0] CODE_MSB16    = 16'h8000;
    localparam logic [1:0]  RANGE_5V      = 2'h3;
    localparam logic [1:0]  RANGE_10V     = 2'h2;
    // Reset values
    localparam logic [11:0] DAC_RST_CODE  = 12'h800;

    typedef enum logic [1:0] {
        AIOCP_TRG_SOFT,
        AIOCP_TRG_EDGE,
        AIOCP_TRG_PATTERN,
        AIOCP_TRG_RSVD
    } aiocp_trig_t;

    typedef enum logic [1:0] {
        AIOCP_AI_IDLE,
        AIOCP_AI_ARMED,
        AIOCP_AI_RUN,
        AIOCP_AI_HALT
    } aiocp_ai_st_t;
endpackage : aiocp_pkg

// >>> rtl/aiocp_fifo.sv
// Small valid/ready FIFO for conversion results
module aiocp_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } aiocp_fifo_st_t;

    aiocp_fifo_st_t st_r;
    aiocp_fifo_st_t st_nxt;
    logic           push;
    logic           pop;

    assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o  = st_r.mem[st_r.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data_i;
            st_nxt.wr = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : aiocp_fifo

// >>> rtl/aiocp_top.sv
// Analog input coding and pacing with buffered, recyclable analog output
// Behaviour
// - Bipolar input results in two's complement
// - Unipolar input results in straight binary
// - Right-justified results, no tags, one format
// - Bipolar 12-bit: upper four bits copy sign
// - Code range fixed regardless of gain
// - Reject pacing below 30 master ticks
// - Pacing divider reaches about 859 seconds
// - Sustain 333 kHz single, 312 kHz scan
// - Detect overrun, flag it, halt acquisition
// - 2K-sample output FIFO, gap-free to 500 kHz
// - Recycle mode replays loaded output samples
// - No sample changes while recycling runs
// - No end-of-buffer indication when recycling
// - Shared pacing advances output on input events
// - External pacing clock, selectable active edge
// - Hardware start trigger, selectable edge
// - Pattern trigger: mask, compare, match/mismatch
// - Recycle simultaneous trigger rewinds replay index
// - Offset-binary output: 0 lowest, 4095 highest
// - Two's complement output, per-channel range
// - Range code -1 is 5V, -2 10V
// - Pacer is two cascaded 16-bit counters
// - Output underflow flags error, stops output
module aiocp_top (
    input  wire logic        CLOCK_I,
    input  wire logic        RESETN_I,
    input  wire logic        ADC_VALID_I,
    input  wire logic [15:0] ADC_DATA_I,
    input  wire logic        ADC_WIDE_I,
    input  wire logic        BIPOLAR_I,
    input  wire logic        SCAN_I,
    output logic             CONV_START_O,
    input  wire logic [15:0] PACE_DIV_LO_I,
    input  wire logic [15:0] PACE_DIV_HI_I,
    input  wire logic        EXT_CLK_SEL_I,
    input  wire logic        EXT_CLK_FALL_I,
    input  wire logic        EXTERNAL_PACER_CLOCK_IN_I,
    output logic             PACE_REJECT_O,
    input  wire logic [1:0]  TRIG_MODE_I,
    input  wire logic        TRIGGER_GATE_IN_I,
    input  wire logic        TRIG_FALL_I,
    input  wire logic [3:0]  DIG_IN_I,
    input  wire logic [3:0]  TRIG_MASK_I,
    input  wire logic [3:0]  TRIG_PATTERN_I,
    input  wire logic        TRIG_MISMATCH_I,
    input  wire logic        AI_START_I,
    input  wire logic        AI_STOP_I,
    output logic             AI_RUN_O,
    output logic [15:0]      AI_DATA_O,
    output logic             AI_VALID_O,
    input  wire logic        AI_READY_I,
    output logic             DATA_LOST_EVENT_O,
    input  wire logic        OVR_CLR_I,
    input  wire logic        AO_WR_I,
    input  wire logic [11:0] AO_WDATA_I,
    input  wire logic        AO_WCH_I,
    output logic             AO_WREADY_O,
    input  wire logic        AO_CLEAR_I,
    input  wire logic        AO_START_I,
    input  wire logic        AO_STOP_I,
    input  wire logic        AO_RECYCLE_I,
    input  wire logic        AO_SHARED_I,
    input  wire logic        AO_SIMUL_I,
    input  wire logic [15:0] AO_DIV_I,
    input  wire logic        AO_OFFSET_BIN_I,
    input  wire logic [1:0]  AO_RANGE0_I,
    input  wire logic [1:0]  AO_RANGE1_I,
    output logic             AO_RUN_O,
    output logic [11:0]      AO_LEVEL_O,
    output logic             AO_UNDERFLOW_O,
    input  wire logic        UF_CLR_I,
    output logic [11:0]      DAC_CODE_O,
    output logic             DAC_CH_O,
    output logic             DAC_STB_O,
    output logic [1:0]       DAC_RANGE_O,
    output logic             RANGE_ERR_O
);
    typedef struct packed {
        logic [5:0]                   tick_cnt;
        logic [15:0]                  pace_lo;
        logic [15:0]                  pace_hi;
        logic                         ext_prev;
        logic                         trg_prev;
        aiocp_pkg::aiocp_ai_st_t      ai_st;
        logic [aiocp_pkg::GUARD_W-1:0] guard;
        logic                         pend;
        logic                         conv;
        logic                         ovr;
        logic                         pace_rej;
        logic                         ao_run;
        logic [15:0]                  ao_cnt;
        logic [aiocp_pkg::AO_AW-1:0]  wr_ptr;
        logic [aiocp_pkg::AO_AW-1:0]  rd_ptr;
        logic [aiocp_pkg::AO_AW:0]    level;
        logic [aiocp_pkg::AO_AW-1:0]  rec_idx;
        logic                         uf;
        logic [11:0]                  dac_code;
        logic                         dac_ch;
        logic                         dac_stb;
        logic [1:0]                   dac_rng;
        logic                         rng_err;
    } aiocp_st_t;

    aiocp_st_t   st_r;
    aiocp_st_t   st_nxt;
    logic [12:0] ao_mem [aiocp_pkg::AO_DEPTH];

    // {invalid, is_10v} of a signed range code
    function automatic logic [1:0] aiocp_range_fn(input logic [1:0] code, input logic offset_bin);
        if (offset_bin) begin
            aiocp_range_fn = 2'h1;
        end else if (code == aiocp_pkg::RANGE_5V) begin
            aiocp_range_fn = 2'h0;
        end else if (code == aiocp_pkg::RANGE_10V) begin
            aiocp_range_fn = 2'h1;
        end else begin
            aiocp_range_fn = 2'h3;
        end
    endfunction : aiocp_range_fn

    // Raw is offset binary; bipolar flips MSB
    function automatic logic [15:0] aiocp_code_fn(input logic [15:0] raw, input logic wide, input logic bip);
        logic [11:0] r12;
        r12 = raw[11:0];
        if (wide) begin
            aiocp_code_fn = bip ? (raw ^ aiocp_pkg::CODE_MSB16) : raw;
        end else if (bip) begin
            r12 = r12 ^ aiocp_pkg::CODE_MSB12;
            aiocp_code_fn = {{4{r12[11]}}, r12};
        end else begin
            aiocp_code_fn = {4'h0, r12};
        end
    endfunction : aiocp_code_fn

    logic        tick;
    logic        int_pace;
    logic        ext_edge;
    logic        trg_edge;
    logic        pat_hit;
    logic        trig_fire;
    logic        pace_evt;
    logic        ai_running;
    logic [31:0] pace_prod;
    logic        pace_bad;
    logic        fifo_in_ready;
    logic        res_valid;
    logic [15:0] res_data;
    logic        ao_wr_ok;
    logic        ao_pace;
    logic [12:0] ao_sample;
    logic [aiocp_pkg::AO_AW-1:0] ao_idx;
    logic [1:0]  rng0;
    logic [1:0]  rng1;

    assign tick      = (st_r.tick_cnt == 6'(aiocp_pkg::TICK_CYC - 1));
    assign pace_prod = PACE_DIV_LO_I * PACE_DIV_HI_I;
    assign pace_bad  = !EXT_CLK_SEL_I && (pace_prod < 32'(aiocp_pkg::MIN_PACE_TICKS));
    // Low counter wraps at one, carrying into the high counter
    assign int_pace  = tick && (st_r.pace_lo <= 16'h1) && (st_r.pace_hi <= 16'h1);
    assign ext_edge  = EXT_CLK_FALL_I ? (st_r.ext_prev && !EXTERNAL_PACER_CLOCK_IN_I)
                                      : (!st_r.ext_prev && EXTERNAL_PACER_CLOCK_IN_I);
    assign trg_edge  = TRIG_FALL_I ? (st_r.trg_prev && !TRIGGER_GATE_IN_I)
                                   : (!st_r.trg_prev && TRIGGER_GATE_IN_I);
    assign pat_hit   = (((DIG_IN_I & TRIG_MASK_I) == TRIG_PATTERN_I) != TRIG_MISMATCH_I);
    assign ai_running = (st_r.ai_st == aiocp_pkg::AIOCP_AI_RUN);
    assign pace_evt  = ai_running && (EXT_CLK_SEL_I ? ext_edge : int_pace);
    assign res_valid = ADC_VALID_I && ai_running;
    assign res_data  = aiocp_code_fn(ADC_DATA_I, ADC_WIDE_I, BIPOLAR_I);

    always_comb begin
        case (aiocp_pkg::aiocp_trig_t'(TRIG_MODE_I))
            aiocp_pkg::AIOCP_TRG_SOFT:    trig_fire = 1'b1;
            aiocp_pkg::AIOCP_TRG_EDGE:    trig_fire = trg_edge;
            aiocp_pkg::AIOCP_TRG_PATTERN: trig_fire = pat_hit;
            default:                      trig_fire = 1'b0;
        endcase
    end

    // Recycle locks the buffer mid-task
    assign ao_wr_ok  = !(st_r.ao_run && AO_RECYCLE_I)
                       && (st_r.level != (aiocp_pkg::AO_AW+1)'(aiocp_pkg::AO_DEPTH));
    assign ao_pace   = AO_SHARED_I ? pace_evt
                                   : (tick && (st_r.ao_cnt <= 16'h1));
    assign ao_idx    = AO_RECYCLE_I ? (st_r.rd_ptr + st_r.rec_idx) : st_r.rd_ptr;
    assign ao_sample = ao_mem[ao_idx];
    assign rng0      = aiocp_range_fn(AO_RANGE0_I, AO_OFFSET_BIN_I);
    assign rng1      = aiocp_range_fn(AO_RANGE1_I, AO_OFFSET_BIN_I);

    always_comb begin
        st_nxt          = st_r;
        st_nxt.conv     = 1'b0;
        st_nxt.dac_stb  = 1'b0;
        st_nxt.ext_prev = EXTERNAL_PACER_CLOCK_IN_I;
        st_nxt.trg_prev = TRIGGER_GATE_IN_I;
        st_nxt.pace_rej = pace_bad;
        st_nxt.tick_cnt = tick ? 6'h0 : st_r.tick_cnt + 6'h1;

        // Pacer reloads while idle: first interval whole
        if (!ai_running) begin
            st_nxt.pace_lo = PACE_DIV_LO_I;
            st_nxt.pace_hi = PACE_DIV_HI_I;
        end else if (tick) begin
            if (st_r.pace_lo <= 16'h1) begin
                st_nxt.pace_lo = PACE_DIV_LO_I;
                st_nxt.pace_hi = (st_r.pace_hi <= 16'h1) ? PACE_DIV_HI_I : st_r.pace_hi - 16'h1;
            end else begin
                st_nxt.pace_lo = st_r.pace_lo - 16'h1;
            end
        end

        // Spacing guard; one early event held
        if (st_r.guard != '0) begin
            st_nxt.guard = st_r.guard - 1'b1;
        end
        if (ai_running && (pace_evt || st_r.pend)) begin
            if (st_r.guard == '0) begin
                st_nxt.conv  = 1'b1;
                st_nxt.pend  = 1'b0;
                st_nxt.guard = SCAN_I ? aiocp_pkg::GUARD_W'(aiocp_pkg::SCAN_MIN_CYC - 1)
                                      : aiocp_pkg::GUARD_W'(aiocp_pkg::SINGLE_MIN_CYC - 1);
            end else begin
                st_nxt.pend = 1'b1;
            end
        end

        case (st_r.ai_st)
            aiocp_pkg::AIOCP_AI_IDLE: begin
                st_nxt.pend = 1'b0;
                if (AI_START_I && !pace_bad) begin
                    st_nxt.ai_st = aiocp_pkg::AIOCP_AI_ARMED;
                end
            end
            aiocp_pkg::AIOCP_AI_ARMED: begin
                if (AI_STOP_I) begin
                    st_nxt.ai_st = aiocp_pkg::AIOCP_AI_IDLE;
                end else if (trig_fire) begin
                    st_nxt.ai_st = aiocp_pkg::AIOCP_AI_RUN;
                end
            end
            aiocp_pkg::AIOCP_AI_RUN: begin
                if (AI_STOP_I) begin
                    st_nxt.ai_st = aiocp_pkg::AIOCP_AI_IDLE;
                end else if (res_valid && !fifo_in_ready) begin
                    st_nxt.ai_st = aiocp_pkg::AIOCP_AI_HALT;
                    st_nxt.pend  = 1'b0;
                end
            end
            aiocp_pkg::AIOCP_AI_HALT: begin
                if (AI_STOP_I) begin
                    st_nxt.ai_st = aiocp_pkg::AIOCP_AI_IDLE;
                end
            end
            default: begin
                st_nxt.ai_st = aiocp_pkg::AIOCP_AI_IDLE;
            end
        endcase

        // Set wins over a clear in the same cycle
        if (OVR_CLR_I) begin
            st_nxt.ovr = 1'b0;
        end
        if (res_valid && !fifo_in_ready) begin
            st_nxt.ovr = 1'b1;
        end

        // Output side
        if (AO_START_I && !AO_STOP_I) begin
            st_nxt.ao_run  = 1'b1;
            st_nxt.rec_idx = '0;
            st_nxt.ao_cnt  = (AO_DIV_I < aiocp_pkg::AO_MIN_TICKS) ? aiocp_pkg::AO_MIN_TICKS : AO_DIV_I;
        end
        if (AO_STOP_I) begin
            st_nxt.ao_run = 1'b0;
        end
        if (st_r.ao_run && tick && !AO_SHARED_I) begin
            // Own divider clamped to the 500 kHz ceiling
            st_nxt.ao_cnt = (st_r.ao_cnt <= 16'h1)
                ? ((AO_DIV_I < aiocp_pkg::AO_MIN_TICKS) ? aiocp_pkg::AO_MIN_TICKS : AO_DIV_I)
                : st_r.ao_cnt - 16'h1;
        end

        if (AO_CLEAR_I && !st_r.ao_run) begin
            st_nxt.wr_ptr = '0;
            st_nxt.rd_ptr = '0;
            st_nxt.level  = '0;
        end else begin
            if (AO_WR_I && ao_wr_ok) begin
                st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
            end
            if (st_r.ao_run && AO_RECYCLE_I && AO_SIMUL_I && trg_edge
                && (aiocp_pkg::aiocp_trig_t'(TRIG_MODE_I) == aiocp_pkg::AIOCP_TRG_EDGE)) begin
                st_nxt.rec_idx = '0;
            end else if (st_r.ao_run && ao_pace) begin
                if (st_r.level == '0) begin
                    if (!AO_RECYCLE_I) begin
                        st_nxt.ao_run = 1'b0;
                    end
                end else begin
                    st_nxt.dac_stb  = 1'b1;
                    st_nxt.dac_ch   = ao_sample[12];
                    // DAC takes offset binary, 0 most negative
                    st_nxt.dac_code = AO_OFFSET_BIN_I ? ao_sample[11:0]
                                                      : (ao_sample[11:0] ^ aiocp_pkg::CODE_MSB12);
                    if (AO_RECYCLE_I) begin
                        // Silent wrap: nothing tells the host a pass has ended
                        st_nxt.rec_idx = ((st_r.rec_idx + 1'b1) == st_r.level[aiocp_pkg::AO_AW-1:0]
                                          && !st_r.level[aiocp_pkg::AO_AW])
                                         ? '0 : st_r.rec_idx + 1'b1;
                    end else begin
                        st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
                    end
                end
            end
            st_nxt.level = st_r.level
                + (aiocp_pkg::AO_AW+1)'(AO_WR_I && ao_wr_ok)
                - (aiocp_pkg::AO_AW+1)'(st_r.ao_run && ao_pace && !AO_RECYCLE_I
                                         && (st_r.level != '0) && (st_nxt.rec_idx == st_r.rec_idx));
        end

        if (UF_CLR_I) begin
            st_nxt.uf = 1'b0;
        end
        if (st_r.ao_run && ao_pace && !AO_RECYCLE_I && (st_r.level == '0)) begin
            st_nxt.uf = 1'b1;
        end

        // Range codes other than -1 and -2 keep the 10 V range
        st_nxt.dac_rng = {rng1[0] | rng1[1], rng0[0] | rng0[1]};
        st_nxt.rng_err = rng0[1] | rng1[1];
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_r          <= '0;
            st_r.ai_st    <= aiocp_pkg::AIOCP_AI_IDLE;
            st_r.dac_code <= aiocp_pkg::DAC_RST_CODE;
            st_r.dac_rng  <= 2'h3;
        end else begin
            st_r <= st_nxt;
        end
    end

    // No reset: only entries below level matter
    always_ff @(posedge CLOCK_I) begin
        if (AO_WR_I && ao_wr_ok && !(AO_CLEAR_I && !st_r.ao_run)) begin
            ao_mem[st_r.wr_ptr] <= {AO_WCH_I, AO_WDATA_I};
        end
    end

    aiocp_fifo #(
        .WIDTH (aiocp_pkg::AD_W),
        .DEPTH (aiocp_pkg::AI_FIFO_DEPTH)
    ) u_ai_fifo (
        .clk_i       (CLOCK_I),
        .rst_n_i     (RESETN_I),
        .in_valid_i  (res_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (res_data),
        .out_valid_o (AI_VALID_O),
        .out_ready_i (AI_READY_I),
        .out_data_o  (AI_DATA_O)
    );

    assign CONV_START_O      = st_r.conv;
    assign PACE_REJECT_O     = st_r.pace_rej;
    assign AI_RUN_O          = ai_running;
    assign DATA_LOST_EVENT_O = st_r.ovr;
    assign AO_WREADY_O       = ao_wr_ok && !(AO_CLEAR_I && !st_r.ao_run);
    assign AO_RUN_O          = st_r.ao_run;
    assign AO_LEVEL_O        = st_r.level;
    assign AO_UNDERFLOW_O    = st_r.uf;
    assign DAC_CODE_O        = st_r.dac_code;
    assign DAC_CH_O          = st_r.dac_ch;
    assign DAC_STB_O         = st_r.dac_stb;
    assign DAC_RANGE_O       = st_r.dac_rng;
    assign RANGE_ERR_O       = st_r.rng_err;
endmodule : aiocp_top

// >>> verif/aiocp_conv_model.sv
// Converter model answering each start pulse with one result
module aiocp_conv_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [15:0] code_i,
    output logic             valid_o,
    output logic [15:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busy;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 4'h0;
            valid_o <= 1'b0;
            data_o <= 16'h0000;
        end else begin
            busy <= start_i ? 4'ha : (busy != 4'h0 ? busy - 4'h1 : 4'h0);
            valid_o <= (busy == 4'h1);
            // Bus carries nothing valid outside the result cycle
            data_o <= (busy == 4'h1) ? code_i : ~data_o;
        end
    end
endmodule : aiocp_conv_model

// >>> verif/aiocp_checker.sv
// Port assertions for the analog I/O coding and pacing block
module aiocp_checker (
    input wire logic        CLOCK_I,
    input wire logic        RESETN_I,
    input wire logic [15:0] PACE_DIV_LO_I,
    input wire logic [15:0] PACE_DIV_HI_I,
    input wire logic        EXT_CLK_SEL_I,
    input wire logic        PACE_REJECT_O,
    input wire logic        CONV_START_O,
    input wire logic        AI_RUN_O,
    input wire logic        AI_VALID_O,
    input wire logic        AI_READY_I,
    input wire logic [15:0] AI_DATA_O,
    input wire logic        DATA_LOST_EVENT_O,
    input wire logic        OVR_CLR_I,
    input wire logic        AO_RUN_O,
    input wire logic        AO_RECYCLE_I,
    input wire logic        AO_WREADY_O,
    input wire logic        AO_UNDERFLOW_O,
    input wire logic        UF_CLR_I,
    input wire logic        DAC_STB_O,
    input wire logic [1:0]  DAC_RANGE_O,
    input wire logic [1:0]  AO_RANGE0_I,
    input wire logic [1:0]  AO_RANGE1_I,
    input wire logic        AO_OFFSET_BIN_I
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    wire logic bad = !EXT_CLK_SEL_I && ({16'h0, PACE_DIV_LO_I} * {16'h0, PACE_DIV_HI_I} < 32'h1e);
    logic [9:0] gap_r;
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) gap_r <= 10'h3ff;
        else if (CONV_START_O) gap_r <= 10'h000;
        else if (gap_r != 10'h3ff) gap_r <= gap_r + 10'h001;
    end
    a_pace_reject: assert property ($past(RESETN_I) |-> PACE_REJECT_O == $past(bad))
        else $error("pace reject mismatch");
    a_conv_spacing: assert property (CONV_START_O |-> gap_r >= 10'h2ed)
        else $error("starts too close");
    a_conv_running: assert property (CONV_START_O |-> $past(AI_RUN_O))
        else $error("start while idle");
    a_lost_halts: assert property ($rose(DATA_LOST_EVENT_O) |-> !AI_RUN_O)
        else $error("run after overrun");
    a_lost_sticky: assert property (DATA_LOST_EVENT_O && !OVR_CLR_I |=> DATA_LOST_EVENT_O)
        else $error("overrun flag lost");
    a_result_held: assert property (AI_VALID_O && !AI_READY_I |=> AI_VALID_O && $stable(AI_DATA_O))
        else $error("result not held");
    a_recycle_locked: assert property (AO_RUN_O && AO_RECYCLE_I |-> !AO_WREADY_O)
        else $error("write in recycle");
    a_underflow_stops: assert property ($rose(AO_UNDERFLOW_O) |-> !AO_RUN_O && !$past(AO_RECYCLE_I))
        else $error("run after underflow");
    a_uf_sticky: assert property (AO_UNDERFLOW_O && !UF_CLR_I |=> AO_UNDERFLOW_O)
        else $error("underflow flag lost");
    a_range_map: assert property ($past(RESETN_I) && !$past(AO_OFFSET_BIN_I)
        |-> DAC_RANGE_O == {$past(AO_RANGE1_I) != 2'h3, $past(AO_RANGE0_I) != 2'h3})
        else $error("range mismatch");
endmodule : aiocp_checker
bind aiocp_top aiocp_checker i_chk (.*);

// >>> verif/tb_top.sv
// Testbench for the analog I/O coding and pacing block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK_I, RESETN_I, ADC_VALID_I, ADC_WIDE_I, BIPOLAR_I, SCAN_I, CONV_START_O, EXT_CLK_SEL_I, EXT_CLK_FALL_I;
    logic EXTERNAL_PACER_CLOCK_IN_I, PACE_REJECT_O, TRIGGER_GATE_IN_I, TRIG_FALL_I, TRIG_MISMATCH_I, AI_START_I;
    logic AI_STOP_I, AI_RUN_O, AI_VALID_O, AI_READY_I, DATA_LOST_EVENT_O, OVR_CLR_I, AO_WR_I, AO_WCH_I, AO_WREADY_O;
    logic AO_CLEAR_I, AO_START_I, AO_STOP_I, AO_RECYCLE_I, AO_SHARED_I, AO_SIMUL_I, AO_OFFSET_BIN_I, AO_RUN_O;
    logic AO_UNDERFLOW_O, UF_CLR_I, DAC_CH_O, DAC_STB_O, RANGE_ERR_O;
    logic [15:0] ADC_DATA_I, PACE_DIV_LO_I, PACE_DIV_HI_I, AI_DATA_O, AO_DIV_I, code;
    logic [11:0] AO_WDATA_I, AO_LEVEL_O, DAC_CODE_O;
    logic [3:0]  DIG_IN_I, TRIG_MASK_I, TRIG_PATTERN_I;
    logic [1:0]  TRIG_MODE_I, AO_RANGE0_I, AO_RANGE1_I, DAC_RANGE_O;
    int fail_count, checked, cyc, i;
    wire logic [3:0] flags = {DATA_LOST_EVENT_O, AO_UNDERFLOW_O, DAC_STB_O, AI_VALID_O};
    // {wide, bipolar}, raw, expected
    logic [33:0] tbl [5] = '{{2'h1, 16'h0000, 16'hf800}, {2'h1, 16'h0fff, 16'h07ff}, {2'h0, 16'h0123, 16'h0123},
                             {2'h3, 16'h0000, 16'h8000}, {2'h2, 16'hffff, 16'hffff}};
    logic [11:0] aos [3] = '{12'h7ff, 12'h800, 12'h001};
    aiocp_top i_dut (.*);
    aiocp_conv_model i_conv (.clk_i(CLOCK_I), .rst_n_i(RESETN_I), .start_i(CONV_START_O), .code_i(code),
                             .valid_o(ADC_VALID_I), .data_o(ADC_DATA_I));
    initial CLOCK_I = 1'b0;
    always #2 CLOCK_I = ~CLOCK_I;
    task tick(input int n);
        repeat (n) @(negedge CLOCK_I);
    endtask : tick
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wait_hi(input int sel, input int lim);
        int n;
        @(negedge CLOCK_I);
        for (n = 0; n < lim && flags[sel] !== 1'b1; n++) @(negedge CLOCK_I);
        chk({15'h0, flags[sel]}, 16'h0001);
    endtask : wait_hi
    task ao_fill(input int n);
        int j;
        for (j = 0; j < n; j++) begin
            AO_WDATA_I = aos[j];
            AO_WR_I = 1'b1;
            tick(1);
        end
        AO_WR_I = 1'b0;
        tick(1);
    endtask : ao_fill
    task close_out;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Whole run needs about 20000 cycles
    always @(posedge CLOCK_I) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            close_out;
        end
    end
    initial begin
        {RESETN_I, ADC_WIDE_I, BIPOLAR_I, SCAN_I, EXT_CLK_SEL_I, EXT_CLK_FALL_I, EXTERNAL_PACER_CLOCK_IN_I, AI_READY_I,
         TRIGGER_GATE_IN_I, TRIG_FALL_I, TRIG_MISMATCH_I, AI_START_I, AI_STOP_I, OVR_CLR_I, AO_WR_I, AO_WCH_I,
         AO_CLEAR_I, AO_START_I, AO_STOP_I, AO_RECYCLE_I, AO_SHARED_I, AO_SIMUL_I, AO_OFFSET_BIN_I, UF_CLR_I} = '0;
        {AO_WDATA_I, DIG_IN_I, TRIG_MASK_I, TRIG_PATTERN_I, TRIG_MODE_I, code} = '0;
        {PACE_DIV_LO_I, PACE_DIV_HI_I, AO_DIV_I} = {16'h0005, 16'h0005, 16'h000a};
        {AO_RANGE0_I, AO_RANGE1_I} = 4'ha;
        {fail_count, checked, cyc} = '0;
        tick(20);
        chk(DAC_CODE_O, 16'h0800);
        RESETN_I = 1'b1;
        tick(2);
        chk(PACE_REJECT_O, 16'h1);
        AI_START_I = 1'b1;
        tick(1);
        AI_START_I = 1'b0;
        tick(3);
        chk(AI_RUN_O, 16'h0);
        PACE_DIV_LO_I = 16'h0006;
        tick(2);
        chk(PACE_REJECT_O, 16'h0);
        AI_START_I = 1'b1;
        tick(1);
        AI_START_I = 1'b0;
        tick(3);
        chk(AI_RUN_O, 16'h1);
        $display("test pacing done");
        for (i = 0; i < 5; i++) begin
            {ADC_WIDE_I, BIPOLAR_I, code} = tbl[i][33:16];
            wait_hi(0, 4000);
            chk(AI_DATA_O, tbl[i][15:0]);
            AI_READY_I = 1'b1;
            tick(1);
            AI_READY_I = 1'b0;
        end
        $display("test coding done");
        wait_hi(3, 10000);
        chk(AI_RUN_O, 16'h0);
        tick(3);
        chk(DATA_LOST_EVENT_O, 16'h1);
        OVR_CLR_I = 1'b1;
        tick(1);
        OVR_CLR_I = 1'b0;
        tick(1);
        chk(DATA_LOST_EVENT_O, 16'h0);
        {AI_STOP_I, AI_READY_I} = 2'h3;
        tick(1);
        AI_STOP_I = 1'b0;
        tick(4);
        AI_READY_I = 1'b0;
        $display("test overrun done");
        ao_fill(3);
        chk(AO_LEVEL_O, 16'h3);
        AO_START_I = 1'b1;
        tick(1);
        AO_START_I = 1'b0;
        for (i = 0; i < 3; i++) begin
            wait_hi(1, 1000);
            chk(DAC_CODE_O, {4'h0, aos[i] ^ 12'h800});
        end
        wait_hi(2, 1000);
        chk(AO_RUN_O, 16'h0);
        {UF_CLR_I, AO_CLEAR_I} = 2'h3;
        tick(1);
        {UF_CLR_I, AO_CLEAR_I} = 2'h0;
        ao_fill(2);
        {AO_RECYCLE_I, AO_START_I} = 2'h3;
        tick(1);
        {AO_START_I, AO_WR_I} = 2'h1;
        tick(1);
        chk(AO_WREADY_O, 16'h0);
        AO_WR_I = 1'b0;
        for (i = 0; i < 3; i++) begin
            wait_hi(1, 1000);
            chk(DAC_CODE_O, {4'h0, aos[i % 2] ^ 12'h800});
        end
        chk(AO_LEVEL_O, 16'h2);
        chk(AO_UNDERFLOW_O, 16'h0);
        AO_STOP_I = 1'b1;
        tick(1);
        AO_STOP_I = 1'b0;
        $display("test output done");
        AO_RANGE0_I = 2'h3;
        tick(2);
        chk(DAC_RANGE_O, 16'h2);
        AO_RANGE1_I = 2'h0;
        tick(2);
        chk(RANGE_ERR_O, 16'h1);
        AO_OFFSET_BIN_I = 1'b1;
        tick(2);
        chk(DAC_RANGE_O, 16'h3);
        $display("test ranges done");
        close_out;
    end
endmodule : tb_top
